/* File: rtl/reset_strap_config_decoder.sv */
// Strap sampler and decoder for clock mode and initial configuration.

// Overview of operation
// RL1: Sample clock-mode straps while reset asserted.
// RL2: Map clock-mode code to PLL setup.
// RL3: Fast clock twice system clock with PLL.
// RL4: Sample three configuration straps during reset.
// RL5: Undriven straps read as default 111.
// RL6: Straps ignored after reset; alternate functions.
// RL7: Code 000: slave, 8-bit, normal base.
// RL8: Code 001: slave, 32-bit, request out.
// RL9: Code 010: slave, 16-bit, normal base.
// RL10: Code 011: companion, 32-bit, grant out.
// RL11: Code 100: core on, 32-bit port.
// RL12: Code 101: core on, 16-bit port.
// RL13: Code 110: slave, chip-select off, alternate base.
// RL14: Code 111: core on, 8-bit default.
// RL15: Float control only with core, not reset.
// RL16: Board drives straps open-collector during reset.
// RL17: Self-driven hard reset held 512 cycles.
// RL18: Decoded values held until next reset.
module reset_strap_config_decoder
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hardResetIn_n,
  input wire logic hardResetRequest,
  input wire logic [1:0] clockModeStraps,
  input wire logic [2:0] initConfigStraps,
  input wire logic pinFloatControl,
  output logic hardResetOut,
  output logic hardResetOe_n,
  output strap_cfg_pkg::pll_setup_s pllSetup,
  output strap_cfg_pkg::init_config_s initConfig,
  output logic fastClockDouble,
  output logic pinsFloat,
  output logic strapPinsReleased
);
  import strap_cfg_pkg::*;

  // ****************************************
  // State
  // ****************************************
  // All state of the block in one record.
  typedef struct packed
  {
    logic [9:0] holdCount;
    logic driving;
    logic inReset;
    logic [1:0] clockCode;
    logic [2:0] configCode;
    pll_setup_s pll;
    init_config_s cfg;
  } state_s;

  state_s cur; // Registered state.
  state_s next_cur; // Next state.
  logic hardAsserted; // Hard reset seen from any source.
  pll_setup_s decodedPll; // Live decode of the clock code.
  init_config_s decodedCfg; // Live decode of the configuration code.

  assign hardAsserted = !hardResetIn_n || cur.driving;

  // Decodes the clock-mode code into a PLL setup.
  always_comb
  begin
    decodedPll = '0;
    // RL2: clock code decode
    unique case (cur.clockCode)
      CLK_MODE_RESERVED:
      begin
        decodedPll = '0;
      end
      CLK_MODE_DIRECT:
      begin
        decodedPll = '{pllEnable: 1'b1, prescaleEnable: 1'b0, pllMultiplier: MULT_UNITY};
      end
      CLK_MODE_PRESCALED:
      begin
        decodedPll = '{pllEnable: 1'b1, prescaleEnable: 1'b1, pllMultiplier: MULT_HIGH};
      end
      CLK_MODE_LOWFREQ:
      begin
        decodedPll = '{pllEnable: 1'b1, prescaleEnable: 1'b0, pllMultiplier: MULT_HIGH};
      end
    endcase
  end

  // Decodes the configuration code into the boot setup.
  always_comb
  begin
    decodedCfg = '0;
    decodedCfg.moduleBaseRegister = BASE_NORMAL;
    unique case (cur.configCode)
      // RL7: slave eight bit
      3'h0:
      begin
        decodedCfg.bootPortWidth = PORT_8;
      end
      // RL8: slave request out
      3'h1:
      begin
        decodedCfg.bootPortWidth = PORT_32;
        decodedCfg.busRequestIsOutput = 1'b1;
      end
      // RL9: slave sixteen bit
      3'h2:
      begin
        decodedCfg.bootPortWidth = PORT_16;
      end
      // RL10: companion grant out
      3'h3:
      begin
        decodedCfg.bootPortWidth = PORT_32;
        decodedCfg.companionMode = 1'b1;
        decodedCfg.busGrantIsOutput = 1'b1;
      end
      // RL11: core thirty-two bit
      3'h4:
      begin
        decodedCfg.coreEnable = 1'b1;
        decodedCfg.bootPortWidth = PORT_32;
      end
      // RL12: core sixteen bit
      3'h5:
      begin
        decodedCfg.coreEnable = 1'b1;
        decodedCfg.bootPortWidth = PORT_16;
      end
      // RL13: alternate base location
      3'h6:
      begin
        decodedCfg.bootPortWidth = PORT_OFF;
        decodedCfg.moduleBaseRegister = BASE_ALTERNATE;
      end
      // RL14: default core eight
      3'h7:
      begin
        decodedCfg.coreEnable = 1'b1;
        decodedCfg.bootPortWidth = PORT_8;
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  // Samples straps during hard reset and freezes them afterwards.
  always_comb
  begin
    next_cur = cur;
    next_cur.inReset = hardAsserted;
    // RL17: minimum hold count
    if (cur.driving)
    begin
      if (cur.holdCount == HARD_RESET_CYCLES - 10'h001)
      begin
        next_cur.driving = hardResetRequest;
        next_cur.holdCount = '0;
      end
      else
      begin
        next_cur.holdCount = cur.holdCount + 10'h001;
      end
    end
    else if (hardResetRequest)
    begin
      next_cur.driving = 1'b1;
      next_cur.holdCount = '0;
    end
    // RL1: sample while reset
    if (hardAsserted)
    begin
      next_cur.clockCode = clockModeStraps;
      // RL4: sample configuration straps
      next_cur.configCode = initConfigStraps;
    end
    // RL18: latch at release
    if (cur.inReset && !hardAsserted)
    begin
      next_cur.pll = decodedPll;
      next_cur.cfg = decodedCfg;
    end
  end

  // Registers the state; reset values give the pull-up default.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur <= '0;
      // RL5: pull-up default code
      cur.configCode <= CFG_DEFAULT;
      cur.clockCode <= CLK_MODE_LOWFREQ;
      cur.inReset <= 1'b1;
      cur.cfg.moduleBaseRegister <= BASE_NORMAL;
      cur.cfg.coreEnable <= 1'b1;
      cur.cfg.bootPortWidth <= PORT_8;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hardResetOut = 1'b0; // Open drain drives only low.
  assign hardResetOe_n = !cur.driving; // Low while the line is pulled.
  assign pllSetup = cur.pll;
  assign initConfig = cur.cfg;
  // RL3: fast clock ratio
  assign fastClockDouble = cur.pll.pllEnable;
  // RL15: immediate float
  // The live hard reset level blocks the float request in the very cycle the line drops.
  // The registered reset flag also blocks it in the one cycle after release,
  // while the core enable still shows the configuration of the previous reset.
  assign pinsFloat = cur.cfg.coreEnable && pinFloatControl && !hardAsserted && !cur.inReset;
  // RL6: alternate functions allowed
  assign strapPinsReleased = !cur.inReset;
endmodule

/* File: rtl/strap_cfg_pkg.sv */
// Package holding constants and carrier types of the reset strap configuration decoder.
package strap_cfg_pkg;

  // ****************************************
  // Clock-mode strap codes and PLL setup
  // ****************************************
  localparam logic [1:0] CLK_MODE_RESERVED = 2'h0; // PLL disabled, reserved.
  localparam logic [1:0] CLK_MODE_DIRECT = 2'h1; // Reference is the crystal input.
  localparam logic [1:0] CLK_MODE_PRESCALED = 2'h2; // Divide by 128, multiplier 401.
  localparam logic [1:0] CLK_MODE_LOWFREQ = 2'h3; // No prescale, multiplier 401.
  localparam logic [8:0] MULT_UNITY = 9'h001; // Multiplier of one.
  localparam logic [8:0] MULT_HIGH = 9'h191; // Multiplier of 401.
  localparam logic [7:0] PRESCALE_DIV = 8'h80; // Prescale divisor of 128.

  // ****************************************
  // Configuration strap codes
  // ****************************************
  localparam logic [2:0] CFG_DEFAULT = 3'h7; // Code left by the internal pull-ups.
  localparam logic [23:0] BASE_NORMAL = 24'h03ff00; // Normal base register location.
  localparam logic [23:0] BASE_ALTERNATE = 24'h03ff04; // Alternate base register location.

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10; // System clock period in ns.
  localparam int HARD_RESET_MIN_CYCLES = 512; // Least hold of a self-driven hard reset.
  localparam logic [9:0] HARD_RESET_CYCLES = 10'(HARD_RESET_MIN_CYCLES);

  // Boot chip-select port width.
  typedef enum logic [1:0]
  {
    PORT_OFF = 2'h0,
    PORT_8 = 2'h1,
    PORT_16 = 2'h2,
    PORT_32 = 2'h3
  } port_width_e;

  // Decoded clock synthesizer setup.
  typedef struct packed
  {
    logic pllEnable;
    logic prescaleEnable;
    logic [8:0] pllMultiplier;
  } pll_setup_s;

  // Decoded initial configuration.
  typedef struct packed
  {
    logic coreEnable;
    logic companionMode;
    logic busRequestIsOutput;
    logic busGrantIsOutput;
    port_width_e bootPortWidth;
    logic [23:0] moduleBaseRegister;
  } init_config_s;

endpackage

/* File: verification/strap_board_model.sv */
// Board model of strap drivers and the hard reset source.
module strap_board_model
(
  input wire logic holdReset,
  input wire logic driveStraps,
  input wire logic [2:0] cfgCode,
  input wire logic [1:0] modeCode,
  input wire logic hardResetOe_n,
  output logic hardResetIn_n,
  output logic [2:0] initConfigStraps,
  output logic [1:0] clockModeStraps
);
  timeunit 1ns;
  timeprecision 1ns;
  assign initConfigStraps = driveStraps ? cfgCode : 3'h7; // Released straps float up.
  assign clockModeStraps = modeCode;
  assign hardResetIn_n = !holdReset && hardResetOe_n; // Open-drain line with pull-up.
endmodule

/* File: verification/strap_cfg_asserts.sv */
// Checker of the strap decoder port relations.
module strap_cfg_asserts
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hardResetIn_n,
  input wire logic pinFloatControl,
  input wire logic hardResetOut,
  input wire logic hardResetOe_n,
  input wire strap_cfg_pkg::pll_setup_s pllSetup,
  input wire strap_cfg_pkg::init_config_s initConfig,
  input wire logic fastClockDouble,
  input wire logic pinsFloat,
  input wire logic strapPinsReleased
);
  import strap_cfg_pkg::*;
  logic [15:0] lowCount; // Cycles the block has pulled hard reset.
  always_ff @(posedge clk)
  begin
    lowCount <= (rst || hardResetOe_n) ? 16'h0 : lowCount + 16'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  hr_out_zero_a: assert property (hardResetOut == 1'b0) else $error("reset data not 0");
  reset_span_a: assert property ($rose(hardResetOe_n) |->
    lowCount[8:0] == 9'h0 && lowCount != 16'h0) else $error("reset pull length wrong");
  float_gate_a: assert property (pinsFloat |-> pinFloatControl &&
    initConfig.coreEnable && hardResetIn_n) else $error("float while not allowed");
  cfg_hold_a: assert property (hardResetIn_n [*3] |=>
    $stable(initConfig) && $stable(pllSetup)) else $error("decode changed");
  fast_double_a: assert property (fastClockDouble == (pllSetup.pllMultiplier != 9'h0))
    else $error("fast clock ratio wrong");
  pll_mult_a: assert property (pllSetup.prescaleEnable |-> pllSetup.pllEnable &&
    pllSetup.pllMultiplier == MULT_HIGH) else $error("prescaled multiplier wrong");
  cs_off_alt_a: assert property (initConfig.bootPortWidth == PORT_OFF |->
    initConfig.moduleBaseRegister == BASE_ALTERNATE && !initConfig.coreEnable)
    else $error("chip-select off decode wrong");
  companion_dir_a: assert property (initConfig.companionMode |->
    initConfig.busGrantIsOutput && !initConfig.busRequestIsOutput) else $error("companion dir");
  released_low_a: assert property (!hardResetIn_n |=> !strapPinsReleased)
    else $error("released during reset");
  cover property (pinsFloat);
  cover property (initConfig.bootPortWidth == PORT_OFF);
  cover property ($rose(hardResetOe_n));
endmodule
bind reset_strap_config_decoder strap_cfg_asserts strap_cfg_asserts_inst(.clk, .rst,
  .hardResetIn_n, .pinFloatControl, .hardResetOut, .hardResetOe_n, .pllSetup,
  .initConfig, .fastClockDouble, .pinsFloat, .strapPinsReleased);

/* File: verification/testbench.sv */
// Self-checking bench of the strap decoder.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import strap_cfg_pkg::*;
  logic clk = 0, rst = 1, hold = 1, drive = 1, req = 0, pfc = 0;
  logic [2:0] code = 3'h7;
  logic [1:0] mode = 2'h3;
  logic [15:0] rnd = 16'hb3f3;
  wire hrIn_n, hrOut, hrOe_n, fast, flt, rel;
  wire [2:0] cfgS;
  wire [1:0] modeS;
  pll_setup_s pll;
  init_config_s cfg;
  int fails = 0, compares = 0, n, k;
  port_width_e widthOf[8] = '{PORT_8, PORT_32, PORT_16, PORT_32, PORT_32, PORT_16,
    PORT_OFF, PORT_8};
  initial forever #5 clk = ~clk;
  strap_board_model strap_board_model_inst(.holdReset(hold), .driveStraps(drive),
    .cfgCode(code), .modeCode(mode), .hardResetOe_n(hrOe_n), .hardResetIn_n(hrIn_n),
    .initConfigStraps(cfgS), .clockModeStraps(modeS));
  reset_strap_config_decoder reset_strap_config_decoder_inst(.clk(clk), .rst(rst),
    .hardResetIn_n(hrIn_n), .hardResetRequest(req), .clockModeStraps(modeS),
    .initConfigStraps(cfgS), .pinFloatControl(pfc), .hardResetOut(hrOut),
    .hardResetOe_n(hrOe_n), .pllSetup(pll), .initConfig(cfg), .fastClockDouble(fast),
    .pinsFloat(flt), .strapPinsReleased(rel));
  // Reference decode of a configuration code.
  function automatic init_config_s expCfg(input logic [2:0] c);
    init_config_s e;
    e.coreEnable = c inside {3'h4, 3'h5, 3'h7};
    e.companionMode = c == 3'h3;
    e.busRequestIsOutput = c == 3'h1;
    e.busGrantIsOutput = c == 3'h3;
    e.bootPortWidth = widthOf[c];
    e.moduleBaseRegister = c == 3'h6 ? BASE_ALTERNATE : BASE_NORMAL;
    return e;
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check_word(input string nm, input logic [39:0] e, input logic [39:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_bit(input string nm, input logic e, input logic g);
    check_word(nm, {39'h0, e}, {39'h0, g});
  endtask
  // One hard reset with the given straps, then strap noise afterwards.
  task automatic run(input logic [2:0] c, input logic [1:0] m, input logic d);
    logic [2:0] ec;
    logic [15:0] r;
    ec = d ? c : 3'h7;
    @(posedge clk);
    code <= c; mode <= m; drive <= d; hold <= 1; pfc <= 1;
    repeat (2) @(posedge clk);
    #1 check_bit("float", 1'b0, flt);
    check_bit("released", 1'b0, rel);
    @(posedge clk);
    hold <= 0;
    repeat (3) @(posedge clk);
    #1 check_word("config", expCfg(ec), cfg);
    check_bit("pll on", m != 2'h0, pll.pllEnable);
    check_bit("fast", m != 2'h0, fast);
    check_bit("released", 1'b1, rel);
    if (m != 2'h0)
      check_word("pll", {m == 2'h2, m == 2'h1 ? MULT_UNITY : MULT_HIGH},
        {pll.prescaleEnable, pll.pllMultiplier});
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      r = lfsr(rnd);
      rnd <= r;
      code <= r[2:0];
      mode <= r[4:3];
      pfc <= r[5];
      #1 check_word("held", expCfg(ec), cfg);
      check_bit("float", r[5] & expCfg(ec).coreEnable, flt);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #100000 fails++;
    tally_and_finish();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 0;
    #1 check_word("reset cfg", expCfg(3'h7), cfg);
    check_bit("oe", 1'b1, hrOe_n);
    check_bit("reset data", 1'b0, hrOut);
    for (n = 0; n < 8; n++)
      run(n[2:0], n[1:0], 1'b1);
    run(3'h0, 2'h2, 1'b0);
    run(rnd[2:0], rnd[4:3], 1'b1);
    @(posedge clk);
    code <= 3'h6; req <= 1;
    @(posedge clk);
    req <= 0;
    n = 0;
    repeat (1200)
    begin
      @(negedge clk);
      if (hrOe_n === 1'b0) n++;
    end
    check_word("pull", 40'd512, 40'(n));
    check_word("self cfg", expCfg(3'h6), cfg);
    tally_and_finish();
  end
endmodule
